// >>> design/rtcam_defs.svh
// Constant macros for the alarm-zero match and interrupt block
`ifndef RTCAM_DEFS_SVH
`define RTCAM_DEFS_SVH

// ==========================================================
// Register offsets on the internal register port
`define RTCAM_OFS_SEC 3'h0
`define RTCAM_OFS_MIN 3'h1
`define RTCAM_OFS_HOUR 3'h2
`define RTCAM_OFS_DATE 3'h3
`define RTCAM_OFS_MONTH 3'h4
`define RTCAM_OFS_WDAY 3'h5
`define RTCAM_OFS_INT 3'h6
`define RTCAM_OFS_STATUS 3'h7

// ==========================================================
// Field positions and reset values
`define RTCAM_FLD_EN_BIT 7
`define RTCAM_INT_ALARM_ZERO_ENABLE_BIT 5
`define RTCAM_INT_IM_BIT 7
`define RTCAM_STATUS_AL0_BIT 0
`define RTCAM_ALARM_RST 8'h00
`define RTCAM_INT_RST 8'h00
`define RTCAM_SEC_ROLL 8'h00

// ==========================================================
// Timing: pulse width of the periodic interrupt
`define RTCAM_CLK_MHZ 32'h14
`define RTCAM_PULSE_NS 32'h3e8
`define RTCAM_PULSE_CYCLES \
   ((`RTCAM_PULSE_NS * `RTCAM_CLK_MHZ + 32'h3e7) / 32'h3e8)

`endif

// >>> design/rtcam_pkg.sv
// Types shared by the alarm-zero match and interrupt block
`default_nettype none
package rtcam_pkg;

   // ==========================================================
   // Pulse sequencer states, Gray coded
   typedef enum logic [1:0] {
      RTCAM_IDLE = 2'b00,
      RTCAM_PULSE = 2'b01
   } rtcam_state_t;

   // ==========================================================
   // Whole state of the block
   typedef struct packed {
      logic [5:0][7:0] alarm;
      logic [7:0] ctrl;
      logic flag;
      rtcam_state_t state;
      logic [15:0] cnt;
      logic irq_n;
      logic [7:0] rdata;
   } rtcam_regs_t;

endpackage
`default_nettype wire

// >>> design/rtcam_alarm.sv
// Alarm-zero field match, status flag and interrupt pin driver
`timescale 1ns/100ps
`default_nettype none
`include "rtcam_defs.svh"

// Summary of operation
// - Alarm fires when enabled fields first match
// - Trigger sets flag and drives pin low
// - Bit 7 enables field, rest BCD
// - Disabled fields never cause nor block, but seconds off waits for 00
// - Control bit 5 enables, bit 7 mode
// - Pulsed mode pulses on every recurrence
// - Pulsed mode sets flag, no clear needed
// - Mode zero gives single event interrupt
module rtcam_alarm #(
   parameter logic [15:0] PULSE_CYCLES = 16'(`RTCAM_PULSE_CYCLES)
) (
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic sec_tick,
   input wire logic [7:0] time_sec,
   input wire logic [7:0] time_min,
   input wire logic [7:0] time_hour,
   input wire logic [7:0] time_date,
   input wire logic [7:0] time_month,
   input wire logic [7:0] time_wday,
   input wire logic reg_wr_en,
   input wire logic reg_rd_en,
   input wire logic [2:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   output logic alarm_zero_flag,
   output logic irq_or_freq_out_n
);

   // ==========================================================
   // Field compare helper
   // A field with its enable clear always counts as a hit
   function automatic logic field_hit(input logic [7:0] alm,
                                      input logic [7:0] now);
      field_hit = !alm[`RTCAM_FLD_EN_BIT] || (alm[6:0] == now[6:0]);
   endfunction

   rtcam_pkg::rtcam_regs_t s_reg;
   rtcam_pkg::rtcam_regs_t s_next;
   logic [5:0][7:0] now;
   logic [5:0] hits;
   logic hit_all;
   logic sec_en;
   logic alarm_zero_enable;
   logic irq_pulse_mode;
   logic trig;
   logic flag_clr;

   // ==========================================================
   // Match detection
   assign now = {time_wday, time_month, time_date, time_hour, time_min,
                 time_sec};

   // One comparator per alarm field
   generate
      for (genvar i = 0; i < 6; i++) begin : g_cmp
         assign hits[i] = field_hit(s_reg.alarm[i], now[i]);
      end
   endgenerate

   assign hit_all = &hits;
   assign sec_en = s_reg.alarm[0][`RTCAM_FLD_EN_BIT];
   assign alarm_zero_enable = s_reg.ctrl[`RTCAM_INT_ALARM_ZERO_ENABLE_BIT];
   assign irq_pulse_mode = s_reg.ctrl[`RTCAM_INT_IM_BIT];
   // Only a tick can start a match, so a held time fires once
   assign trig = sec_tick && alarm_zero_enable && hit_all &&
                 (sec_en || time_sec == `RTCAM_SEC_ROLL);
   // Writing zero to the flag bit clears it
   assign flag_clr = reg_wr_en && reg_addr == `RTCAM_OFS_STATUS &&
                     !reg_wdata[`RTCAM_STATUS_AL0_BIT];

   // ==========================================================
   // Next state
   always_comb begin
      s_next = s_reg;
      if (reg_wr_en) begin
         case (reg_addr)
            `RTCAM_OFS_INT: s_next.ctrl = reg_wdata;
            `RTCAM_OFS_STATUS: s_next.flag = s_reg.flag;
            default: s_next.alarm[reg_addr] = reg_wdata;
         endcase
      end
      // Set beats clear so an alarm on the clearing write is kept
      if (flag_clr) begin
         s_next.flag = 1'b0;
      end
      if (trig) begin
         s_next.flag = 1'b1;
      end
      // Pulse sequencer; a new match restarts the pulse
      case (s_reg.state)
         rtcam_pkg::RTCAM_IDLE: begin
            if (trig && irq_pulse_mode) begin
               s_next.state = rtcam_pkg::RTCAM_PULSE;
               s_next.cnt = PULSE_CYCLES - 16'h0001;
            end
         end
         rtcam_pkg::RTCAM_PULSE: begin
            if (trig && irq_pulse_mode) begin
               s_next.cnt = PULSE_CYCLES - 16'h0001;
            end else if (s_reg.cnt == 16'h0000) begin
               s_next.state = rtcam_pkg::RTCAM_IDLE;
            end else begin
               s_next.cnt = s_reg.cnt - 16'h0001;
            end
         end
         default: begin
            s_next.state = rtcam_pkg::RTCAM_IDLE;
            s_next.cnt = 16'h0000;
         end
      endcase
      // Pin low during a pulse, or while a single event is pending
      s_next.irq_n = !((s_next.state == rtcam_pkg::RTCAM_PULSE) ||
                       (s_next.flag && !s_next.ctrl[`RTCAM_INT_IM_BIT] &&
                        s_next.ctrl[`RTCAM_INT_ALARM_ZERO_ENABLE_BIT]));
      // Registered read data; unused bits of status read zero
      if (reg_rd_en) begin
         case (reg_addr)
            `RTCAM_OFS_INT: s_next.rdata = s_reg.ctrl;
            `RTCAM_OFS_STATUS: s_next.rdata = {7'h00, s_reg.flag};
            default: s_next.rdata = s_reg.alarm[reg_addr];
         endcase
      end
   end

   // ==========================================================
   // State register
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         s_reg.alarm <= {6{`RTCAM_ALARM_RST}};
         s_reg.ctrl <= `RTCAM_INT_RST;
         s_reg.flag <= 1'b0;
         s_reg.state <= rtcam_pkg::RTCAM_IDLE;
         s_reg.cnt <= 16'h0000;
         s_reg.irq_n <= 1'b1;
         s_reg.rdata <= 8'h00;
      end else begin
         s_reg <= s_next;
      end
   end

   assign reg_rdata = s_reg.rdata;
   assign alarm_zero_flag = s_reg.flag;
   assign irq_or_freq_out_n = s_reg.irq_n;

   // ==========================================================
   // Checks
   // Cycles since the last pulsed trigger, kept apart from the
   // sequencer's own counter so the width check is independent of it;
   // saturates at all ones while no pulse is running
   logic [15:0] pulse_age;

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         pulse_age <= 16'hffff;
      end else if (trig && irq_pulse_mode) begin
         pulse_age <= 16'h0001;
      end else if (pulse_age != 16'hffff) begin
         pulse_age <= pulse_age + 16'h0001;
      end
   end

   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (sys_rst);

   a_flag_on_trig:
      assert property (trig |=> alarm_zero_flag && !irq_or_freq_out_n)
      else $error("Alarm trigger did not set flag and pin");
   a_roll_only:
      assert property (sec_tick && !sec_en && time_sec != 8'h00 |-> !trig)
      else $error("Alarm without seconds fired off rollover");
   a_field_mask:
      assert property (sec_tick && alarm_zero_enable && sec_en &&
                       time_sec[6:0] == s_reg.alarm[0][6:0] &&
                       s_reg.alarm[1][7] == 1'b0 && s_reg.alarm[2][7] == 1'b0
                       && s_reg.alarm[3][7] == 1'b0 &&
                       s_reg.alarm[4][7] == 1'b0 && s_reg.alarm[5][7] == 1'b0
                       |-> trig)
      else $error("Disabled field blocked a seconds match");
   a_bcd_mismatch:
      assert property (sec_en && time_sec[6:0] != s_reg.alarm[0][6:0]
                       |-> !trig)
      else $error("Enabled seconds field mismatch still fired");
   a_enable_gate:
      assert property (!alarm_zero_enable |-> !trig)
      else $error("Alarm fired while disabled");
   a_pulse_low:
      assert property (irq_pulse_mode && pulse_age <= PULSE_CYCLES
                       |-> !irq_or_freq_out_n)
      else $error("Periodic pulse too short");
   a_pulse_end:
      assert property (irq_pulse_mode &&
                       pulse_age == PULSE_CYCLES + 16'h0001
                       |-> irq_or_freq_out_n)
      else $error("Periodic pulse did not end");
   a_pulse_repeat:
      assert property (s_reg.state == rtcam_pkg::RTCAM_IDLE &&
                       alarm_zero_flag && trig && irq_pulse_mode
                       |=> s_reg.state == rtcam_pkg::RTCAM_PULSE)
      else $error("Set flag blocked the next pulse");
   a_single_once:
      assert property (trig && !irq_pulse_mode && s_reg.state ==
                       rtcam_pkg::RTCAM_IDLE |=> s_reg.state ==
                       rtcam_pkg::RTCAM_IDLE)
      else $error("Single event mode started a pulse");
   a_single_hold:
      assert property (!irq_pulse_mode && alarm_zero_enable &&
                       alarm_zero_flag && !flag_clr && !reg_wr_en
                       |=> !irq_or_freq_out_n)
      else $error("Single event released before clear");
   a_single_free:
      assert property ($fell(alarm_zero_flag) && !irq_pulse_mode &&
                       s_reg.state == rtcam_pkg::RTCAM_IDLE
                       |-> irq_or_freq_out_n)
      else $error("Pin stayed low after flag clear");

   c_single: cover property (trig && !irq_pulse_mode);
   c_pulse: cover property (trig && irq_pulse_mode);
   c_set_clear: cover property (trig && flag_clr);
   c_rollover: cover property (trig && !sec_en);
   c_pulse_done: cover property (pulse_age == PULSE_CYCLES + 16'h0001);

endmodule
`default_nettype wire

// >>> tb/rtcam_time_src.sv
// Time source model: BCD seconds and minutes with a second tick
`timescale 1ns/100ps
`default_nettype none
module rtcam_time_src #(
   parameter int TICK_DIV = 8
) (
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic load,
   input wire logic [7:0] load_sec,
   input wire logic [7:0] load_min,
   output logic sec_tick,
   output logic [7:0] time_sec,
   output logic [7:0] time_min
);
   int div;
   function automatic logic [7:0] bcd_inc(input logic [7:0] v);
      return (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : v + 8'h01;
   endfunction
   // Tick is high in the cycle that shows the advanced time
   always_ff @(posedge core_clk) begin
      sec_tick <= 1'b0;
      if (sys_rst || load) begin
         div <= 0;
         time_sec <= load ? load_sec : 8'h00;
         time_min <= load ? load_min : 8'h00;
      end else if (div == TICK_DIV - 1) begin
         div <= 0;
         sec_tick <= 1'b1;
         time_sec <= (time_sec == 8'h59) ? 8'h00 : bcd_inc(time_sec);
         if (time_sec == 8'h59) begin
            time_min <= (time_min == 8'h59) ? 8'h00 : bcd_inc(time_min);
         end
      end else begin
         div <= div + 1;
      end
   end
endmodule
`default_nettype wire

// >>> tb/tb_top.sv
// Self-checking bench for the alarm-zero match block
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   localparam int PW = 2;
   logic core_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic load = 1'b0;
   logic [7:0] ld_sec = 8'h00;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [2:0] addr = 3'h0;
   logic [7:0] wdata = 8'h00;
   logic sec_tick, flag, pin_n;
   logic [7:0] t_sec, t_min, rdata;
   int n_fail = 0;
   int cmp_count = 0;
   int cyc = 0;
   int n;
   rtcam_time_src src (.core_clk(core_clk), .sys_rst(sys_rst),
      .load(load), .load_sec(ld_sec), .load_min(8'h05),
      .sec_tick(sec_tick), .time_sec(t_sec), .time_min(t_min));
   rtcam_alarm #(.PULSE_CYCLES(16'(PW))) dut (.core_clk(core_clk),
      .sys_rst(sys_rst), .sec_tick(sec_tick), .time_sec(t_sec),
      .time_min(t_min), .time_hour(8'h11), .time_date(8'h01),
      .time_month(8'h01), .time_wday(8'h03), .reg_wr_en(wr),
      .reg_rd_en(rd), .reg_addr(addr), .reg_wdata(wdata),
      .reg_rdata(rdata), .alarm_zero_flag(flag),
      .irq_or_freq_out_n(pin_n));
   // ==========================================================
   // Clock and hang guard
   initial begin
      forever #25 core_clk = ~core_clk;
   end
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_fail++;
         print_verdict();
      end
   end
   // ==========================================================
   // Shared tasks
   task automatic chk(string nm, logic [7:0] exp, logic [7:0] got);
      cmp_count++;
      if (got !== exp) begin
         n_fail++;
         $display("ERROR %s exp %h got %h", nm, exp, got);
      end
   endtask
   task automatic reg_wr(logic [2:0] a, logic [7:0] d);
      @(posedge core_clk) #1;
      {wr, addr, wdata} = {1'b1, a, d};
      @(posedge core_clk) #1;
      wr = 1'b0;
   endtask
   task automatic reg_rd(logic [2:0] a, logic [7:0] exp);
      @(posedge core_clk) #1;
      {rd, addr} = {1'b1, a};
      @(posedge core_clk) #1;
      rd = 1'b0;
      chk("rdata", exp, rdata);
   endtask
   task automatic set_time(logic [7:0] s);
      @(posedge core_clk) #1;
      {load, ld_sec} = {1'b1, s};
      @(posedge core_clk) #1;
      load = 1'b0;
   endtask
   // Bounded wait for the pin level; n holds cycles waited
   task automatic wait_pin(logic lvl, int lim);
      n = 0;
      while (pin_n !== lvl && n < lim) begin
         @(posedge core_clk) #1;
         n++;
      end
      chk("pin wait", {7'h0, lvl}, {7'h0, pin_n});
   endtask
   // ==========================================================
   // Scenarios
   task automatic t_single;
      reg_wr(3'h1, 8'h86);
      reg_wr(3'h6, 8'h20);
      set_time(8'h57);
      wait_pin(1'b0, 100);
      chk("roll sec", 8'h00, t_sec);
      chk("flag", 8'h01, {7'h0, flag});
      reg_rd(3'h7, 8'h01);
      reg_rd(3'h1, 8'h86);
      repeat (40) @(posedge core_clk);
      #1 chk("held pin", 8'h00, {7'h0, pin_n});
      reg_wr(3'h7, 8'h00);
      chk("clr pin", 8'h01, {7'h0, pin_n});
      chk("clr flag", 8'h00, {7'h0, flag});
   endtask
   task automatic t_pulsed;
      reg_wr(3'h1, 8'h00);
      reg_wr(3'h0, 8'hb0);
      reg_wr(3'h6, 8'ha0);
      set_time(8'h27);
      for (int k = 0; k < 3; k++) begin
         wait_pin(1'b0, 1000);
         chk("match sec", 8'h30, t_sec);
         chk("pulse flag", 8'h01, {7'h0, flag});
         wait_pin(1'b1, 50);
         chk("pulse len", 8'(PW), 8'(n));
         // The second pulse came with the flag still set; clear it so
         // the third shows that each trigger sets it again
         if (k == 1) begin
            reg_wr(3'h7, 8'h00);
            chk("pulse clr", 8'h00, {7'h0, flag});
         end
      end
   endtask
   task automatic t_off;
      reg_wr(3'h7, 8'h00);
      reg_wr(3'h6, 8'h80);
      reg_rd(3'h6, 8'h80);
      set_time(8'h27);
      repeat (60) @(posedge core_clk);
      #1 chk("off pin", 8'h01, {7'h0, pin_n});
      chk("off flag", 8'h00, {7'h0, flag});
   endtask
   task automatic print_verdict;
      $display("Comparisons %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   // ==========================================================
   // Main sequence
   initial begin
      repeat (20) @(posedge core_clk);
      #1 sys_rst = 1'b0;
      reg_rd(3'h6, 8'h00);
      chk("rst pin", 8'h01, {7'h0, pin_n});
      t_single();
      t_pulsed();
      t_off();
      print_verdict();
   end
endmodule
`default_nettype wire
